//--- hdl/marker_defines.svh
// constants for the sample lsb marker insertion block
`ifndef MARKER_DEFINES_SVH
`define MARKER_DEFINES_SVH
`define MRK_ADDR_W 10
`define MRK_CTRL_OFS 10'h160
`define MRK_MODE_OFS 10'h164
`define MRK_STAT_OFS 10'h168
`define MRK_CTRL_RESET 8'h00
`define MRK_MODE_RESET 8'h00
`define MRK_EN_BIT 0
`define MRK_CAL_BIT 1
`define MRK_DECIM_LSB 0
`define MRK_DECIM_MSB 4
`define MRK_DECIM_ONE 5'h01
`define MRK_RES_BIT 5
`define MRK_CS_ILA 2'h0
`define MRK_LATENCY 4
`define MRK_SAMPLE_W 12
`define MRK_SYNC_STAGES 3
`define MRK_SYNC_MID (`MRK_SYNC_STAGES-2)
`define MRK_SYNC_LAST (`MRK_SYNC_STAGES-1)
`define MRK_RXEN_BIT 6
`endif

//--- hdl/marker_delay_line.sv
// fixed-latency delay line for the marker bit
`timescale 1ns/10ps
`include "marker_defines.svh"
module marker_delay_line (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_bit,
  output logic o_bit
);
  import marker_pkg::*;
  logic [`MRK_LATENCY-1:0] pipe_r;

  // match the sample path depth
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= {pipe_r[`MRK_LATENCY-2:0], i_bit};
    end
  end
  assign o_bit = pipe_r[`MRK_LATENCY-1];
endmodule : marker_delay_line

//--- hdl/marker_pkg.sv
// types for the sample lsb marker insertion block
package marker_pkg;
  typedef enum logic [1:0] {
    RES_12_type = 2'h0,
    RES_8_type = 2'h1
  } res_type;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1,
    BUS_HOLD = 2'h3
  } bus_state_type;
endpackage : marker_pkg

//--- hdl/sample_lsb_marker_insert.sv
// sample lsb marker insertion with avalon-mm control registers
`timescale 1ns/10ps
`include "marker_defines.svh"
module sample_lsb_marker_insert (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [`MRK_ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_marker_pin,
  input wire logic i_sample_valid,
  input wire logic [`MRK_SAMPLE_W-1:0] i_sample,
  input wire logic i_cal_state,
  output logic o_sample_valid,
  output logic [`MRK_SAMPLE_W-1:0] o_sample,
  output logic [1:0] o_ila_cs,
  output logic o_mark_input_receiver_enable,
  output marker_pkg::res_type o_res
);
  import marker_pkg::*;

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  bus_state_type bus_r;
  bus_state_type bus_nxt;
  logic [31:0] rdata_r;
  logic active;
  logic cal_en;
  logic marker_en;
  logic insert_ok;
  logic [`MRK_SYNC_STAGES-1:0] sync_r;
  logic marker_r;
  logic marker_dly;
  logic [`MRK_SAMPLE_W-1:0] data_r;
  logic valid_r;
  logic cal_r;

  function automatic logic [31:0] reg_read(input logic [`MRK_ADDR_W-1:0] a,
                                           input logic [7:0] c,
                                           input logic [7:0] m,
                                           input logic s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `MRK_CTRL_OFS: v = {24'h00_0000, c};
      `MRK_MODE_OFS: v = {24'h00_0000, m};
      `MRK_STAT_OFS: v = {31'h0000_0000, s};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  // put one flag bit on the sample lsb, keep the data bits above it
  function automatic logic [`MRK_SAMPLE_W-1:0] place_lsb(input logic [`MRK_SAMPLE_W-1:0] d,
                                                        input logic b);
    return {d[`MRK_SAMPLE_W-1:1], b};
  endfunction : place_lsb

  assign active = i_read | i_write;

  // one-cycle wait then acknowledge
  always_comb begin
    bus_nxt = bus_r;
    unique case (bus_r)
      BUS_IDLE: if (active) bus_nxt = BUS_ACK;
      BUS_ACK: bus_nxt = BUS_HOLD;
      BUS_HOLD: bus_nxt = BUS_IDLE;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bus_r <= BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  assign o_waitrequest = active & (bus_r != BUS_ACK);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_r <= `MRK_CTRL_RESET;
      mode_r <= `MRK_MODE_RESET;
    end else if (i_write && bus_r == BUS_ACK) begin
      if (i_address == `MRK_CTRL_OFS) begin
        ctrl_r <= i_writedata[7:0];
      end
      if (i_address == `MRK_MODE_OFS) begin
        mode_r <= i_writedata[7:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_read && bus_r == BUS_IDLE) begin
      rdata_r <= reg_read(i_address, ctrl_r, mode_r, insert_ok);
    end
  end
  assign o_readdata = rdata_r;

  // ****************************************
  // mode decode
  // ****************************************
  assign marker_en = ctrl_r[`MRK_EN_BIT];
  assign cal_en = ctrl_r[`MRK_CAL_BIT];
  assign insert_ok = marker_en
    && mode_r[`MRK_DECIM_MSB:`MRK_DECIM_LSB] == `MRK_DECIM_ONE;
  assign o_mark_input_receiver_enable = mode_r[`MRK_RXEN_BIT];
  assign o_res = mode_r[`MRK_RES_BIT] ? RES_8_type : RES_12_type;
  assign o_ila_cs = `MRK_CS_ILA;

  // ****************************************
  // marker input synchroniser
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_r <= '0;
      marker_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[`MRK_SYNC_STAGES-2:0], i_marker_pin};
      if (sync_r[`MRK_SYNC_MID] == sync_r[`MRK_SYNC_LAST]) begin
        marker_r <= sync_r[`MRK_SYNC_LAST];
      end
    end
  end

  marker_delay_line u_delay (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_bit(marker_r),
    .o_bit(marker_dly)
  );

  // ****************************************
  // sample path
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      data_r <= '0;
      valid_r <= 1'b0;
      cal_r <= 1'b0;
    end else begin
      data_r <= i_sample;
      valid_r <= i_sample_valid;
      cal_r <= i_cal_state;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sample <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= valid_r;
      if (insert_ok) begin
        // bit zero in both widths, data is lsb-aligned
        o_sample <= place_lsb(data_r, marker_dly);
      end else if (cal_en) begin
        o_sample <= place_lsb(data_r, cal_r);
      end else begin
        o_sample <= data_r;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_ila_cs_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    o_ila_cs == 2'h0) else $error("ila cs field not zero");

  chk_marker_lsb: assert property (@(posedge i_clock) disable iff (i_rst)
    insert_ok |=> o_sample[0] == $past(marker_dly))
    else $error("marker not on lsb");

  chk_marker_pri: assert property (@(posedge i_clock) disable iff (i_rst)
    (insert_ok && cal_en) |=> o_sample[0] == $past(marker_dly))
    else $error("cal flag overrode marker");

  chk_pass_through: assert property (@(posedge i_clock) disable iff (i_rst)
    (!marker_en && !cal_en) |=> o_sample == $past(data_r))
    else $error("sample altered while disabled");

  chk_decim_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    (marker_en && mode_r[`MRK_DECIM_MSB:`MRK_DECIM_LSB] != `MRK_DECIM_ONE && !cal_en)
      |=> o_sample == $past(data_r))
    else $error("marker inserted while decimating");

  sequence marker_rise_s;
    $rose(marker_r);
  endsequence
  chk_marker_latency: assert property (@(posedge i_clock) disable iff (i_rst)
    marker_rise_s |-> ##4 marker_dly)
    else $error("marker latency wrong");

  chk_upper_bits: assert property (@(posedge i_clock) disable iff (i_rst)
    insert_ok |=> o_sample[`MRK_SAMPLE_W-1:1] == $past(data_r[`MRK_SAMPLE_W-1:1]))
    else $error("sample data bits altered");

  chk_wait_bounded: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(active) |-> ##[0:2] !o_waitrequest)
    else $error("bus answer late");

  // ****************************************
  // register bus checks
  // ****************************************
  sequence ctrl_write_s;
    i_write && !o_waitrequest && i_address == `MRK_CTRL_OFS;
  endsequence

  sequence mode_write_s;
    i_write && !o_waitrequest && i_address == `MRK_MODE_OFS;
  endsequence

  sequence ctrl_read_s;
    i_read && !o_waitrequest && i_address == `MRK_CTRL_OFS;
  endsequence

  sequence stat_read_s;
    i_read && !o_waitrequest && i_address == `MRK_STAT_OFS;
  endsequence

  chk_idle_no_wait: assert property (@(posedge i_clock) disable iff (i_rst)
    !active |-> !o_waitrequest)
    else $error("waitrequest high without request");

  chk_ack_single: assert property (@(posedge i_clock) disable iff (i_rst)
    bus_r == BUS_ACK |=> bus_r == BUS_HOLD)
    else $error("acknowledge longer than one cycle");

  chk_ctrl_write: assert property (@(posedge i_clock) disable iff (i_rst)
    ctrl_write_s |=> ctrl_r == $past(i_writedata[7:0]))
    else $error("control write lost");

  chk_mode_write: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_write_s |=> mode_r == $past(i_writedata[7:0]))
    else $error("mode write lost");

  chk_ctrl_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    !(i_write && !o_waitrequest) |=> $stable(ctrl_r))
    else $error("control changed without write");

  chk_ctrl_read: assert property (@(posedge i_clock) disable iff (i_rst)
    ctrl_read_s |-> o_readdata == {24'h00_0000, ctrl_r})
    else $error("control readback wrong");

  chk_stat_read: assert property (@(posedge i_clock) disable iff (i_rst)
    stat_read_s |-> o_readdata == {31'h0000_0000, insert_ok})
    else $error("status readback wrong");

  chk_unmapped_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_read && !o_waitrequest && i_address != `MRK_CTRL_OFS && i_address != `MRK_MODE_OFS
      && i_address != `MRK_STAT_OFS) |-> o_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // ****************************************
  // sample path checks
  // ****************************************
  sequence plain_pair_s;
    (!marker_en && !cal_en) ##1 (!marker_en && !cal_en);
  endsequence

  sequence marker_fall_s;
    $fell(marker_r);
  endsequence

  chk_valid_delay: assert property (@(posedge i_clock) disable iff (i_rst)
    1'b1 |-> ##2 (o_sample_valid == $past(i_sample_valid, 2)))
    else $error("sample valid latency wrong");

  chk_plain_delay: assert property (@(posedge i_clock) disable iff (i_rst)
    plain_pair_s |=> o_sample == $past(i_sample, 2))
    else $error("sample not passed through");

  chk_cal_lsb: assert property (@(posedge i_clock) disable iff (i_rst)
    (!insert_ok && cal_en) |=> o_sample[0] == $past(cal_r))
    else $error("cal flag missing from lsb");

  chk_marker_fall: assert property (@(posedge i_clock) disable iff (i_rst)
    marker_fall_s |-> ##4 !marker_dly)
    else $error("marker fall latency wrong");

  chk_sync_agree: assert property (@(posedge i_clock) disable iff (i_rst)
    $changed(marker_r) |-> $past(sync_r[`MRK_SYNC_MID]) == $past(sync_r[`MRK_SYNC_LAST]))
    else $error("marker taken before stages agreed");

endmodule : sample_lsb_marker_insert

//--- test/marker_link_receiver.sv
// link receiver model that captures the sample lanes
`timescale 1ns/10ps
module marker_link_receiver (
  input wire logic i_clock,
  input wire logic i_valid,
  input wire logic [11:0] i_word,
  output logic [11:0] o_word
);
  // keep the last valid sample off the link
  always_ff @(posedge i_clock) begin
    if (i_valid) begin
      o_word <= i_word;
    end
  end
endmodule : marker_link_receiver

//--- test/sample_lsb_marker_insert_tb_top.sv
// testbench for the sample lsb marker insertion block
`timescale 1ns/10ps
`include "marker_defines.svh"
module sample_lsb_marker_insert_tb_top;
  import marker_pkg::*;
  logic i_clock = 0, i_rst = 1, i_read = 0, i_write = 0, i_marker_pin = 0;
  logic i_sample_valid = 0, i_cal_state = 0, o_waitrequest, o_sample_valid, o_rx_en;
  logic [`MRK_ADDR_W-1:0] i_address = '0;
  logic [31:0] i_writedata = '0, o_readdata, rd;
  logic [11:0] i_sample = '0, o_sample, rx_word;
  logic [1:0] o_ila_cs;
  res_type o_res;
  int fail_count = 0, checked = 0, cycles = 0;
  always #5 i_clock = ~i_clock;
  sample_lsb_marker_insert sample_lsb_marker_insert_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_marker_pin(i_marker_pin),
    .i_sample_valid(i_sample_valid), .i_sample(i_sample), .i_cal_state(i_cal_state),
    .o_sample_valid(o_sample_valid), .o_sample(o_sample), .o_ila_cs(o_ila_cs),
    .o_mark_input_receiver_enable(o_rx_en), .o_res(o_res));
  marker_link_receiver marker_link_receiver_i (.i_clock(i_clock), .i_valid(o_sample_valid),
    .i_word(o_sample), .o_word(rx_word));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("counts: %0d checked, %0d mismatches", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] adr, input logic [31:0] wd);
    i_write <= wr;
    i_read <= !wr;
    i_address <= adr;
    i_writedata <= wd;
    do begin
      @(posedge i_clock);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clock);
  endtask : bus
  // steady stream; e4 = bit0 expected 4 edges after the marker change
  task automatic stream(input logic mk, cal, input logic [11:0] s, exp, msk, input logic e4);
    i_marker_pin <= mk;
    i_cal_state <= cal;
    i_sample <= s;
    i_sample_valid <= 1;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    check("early lsb", e4, o_sample[0]);
    repeat (14) @(posedge i_clock);
    @(negedge i_clock);
    check("sample", exp & msk, o_sample & msk);
    check("rx word", exp & msk, rx_word & msk);
    check("valid", 1, o_sample_valid);
    @(posedge i_clock);
  endtask : stream
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 0;
    @(posedge i_clock);
    bus(0, `MRK_CTRL_OFS, 0);
    check("ctrl reset", 32'h00000000, rd);
    bus(0, `MRK_MODE_OFS, 0);
    check("mode reset", 32'h00000000, rd);
    bus(0, 10'h170, 0);
    check("unmapped", 32'h00000000, rd);
    $display("test reset done");
    stream(1, 0, 12'hA5A, 12'hA5A, 12'hFFF, 0);
    stream(0, 0, 12'hA5B, 12'hA5B, 12'hFFF, 1);
    bus(1, `MRK_MODE_OFS, 32'h42);
    bus(1, `MRK_CTRL_OFS, 32'h01);
    bus(0, `MRK_CTRL_OFS, 0);
    check("ctrl rw", 32'h00000001, rd);
    bus(0, `MRK_STAT_OFS, 0);
    check("status decim", 32'h00000000, rd);
    stream(1, 0, 12'hA5A, 12'hA5A, 12'hFFF, 0);
    $display("test passthrough done");
    bus(1, `MRK_MODE_OFS, 32'h41);
    bus(1, `MRK_CTRL_OFS, 32'h03);
    bus(0, `MRK_STAT_OFS, 0);
    check("status", 32'h00000001, rd);
    check("rx enable", 1, o_rx_en);
    stream(0, 1, 12'hA5B, 12'hA5A, 12'hFFF, 1);
    stream(1, 1, 12'hA5A, 12'hA5B, 12'hFFF, 0);
    check("ila cs", 0, o_ila_cs);
    $display("test insert 12-bit done");
    bus(1, `MRK_MODE_OFS, 32'h61);
    check("res", RES_8_type, o_res);
    stream(0, 0, 12'hA51, 12'hA50, 12'h0FF, 1);
    stream(1, 0, 12'hA50, 12'hA51, 12'h0FF, 0);
    check("ila cs", 0, o_ila_cs);
    $display("test insert 8-bit done");
    bus(1, `MRK_CTRL_OFS, 32'h00);
    stream(1, 0, 12'hA5A, 12'hA5A, 12'hFFF, 0);
    bus(1, `MRK_CTRL_OFS, 32'h02);
    stream(0, 1, 12'hA5A, 12'hA5B, 12'hFFF, 1);
    $display("test disable done");
    stop_test();
  end
endmodule : sample_lsb_marker_insert_tb_top
